// *** rtl/prl_pkg.sv ***
// Functional notes
// RULE1: Six port banks at 0xN4xx, prio7 at 0x417
// RULE2: Ingress codes: 7-bit R/W, reset zero
// RULE3: Ingress writes pend until prio7 write commits
// RULE4: Egress codes: 7-bit R/W, reset zero
// RULE5: Egress writes pend until queue3 write commits
// RULE6: Port-based mode uses only queue0 code
// RULE7: Queue 1-3 codes only in queue mode
// RULE8: Codes decode via shared rate table
// RULE9: Bit 7 writes ignored, reads zero
`default_nettype none
package prl_pkg;
	// Port banks and code geometry
	localparam int PRL_PORTS     = 6;
	localparam int PRL_ING_CODES = 8;
	localparam int PRL_EGR_CODES = 4;
	localparam int PRL_CODE_W    = 7;
	localparam int PRL_RATE_W    = 21;
	localparam int PRL_ADDR_W    = 18;
	localparam int PRL_DATA_W    = 32;
	localparam logic [3:0] PRL_PORT_NUM [PRL_PORTS] =
		'{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};

	// Register indices; byte address is four times the index
	localparam logic [11:0] PRL_IDX_ING_BASE   = 12'h410;
	localparam logic [11:0] PRL_IDX_ING_COMMIT = 12'h417;
	localparam logic [11:0] PRL_IDX_EGR_BASE   = 12'h420;
	localparam logic [11:0] PRL_IDX_EGR_COMMIT = 12'h423;
	localparam logic [15:0] PRL_IDX_MODE       = 16'h0030;
	localparam logic [15:0] PRL_IDX_STATUS     = 16'h0031;
	localparam int          PRL_MODE_PORT_BIT  = 3;
	localparam int          PRL_STAT_EGR_LSB   = 8;
	localparam logic [6:0]  PRL_CODE_RST       = 7'h00;

	// Speed selection
	localparam logic [1:0] PRL_SPD_10M  = 2'h0;
	localparam logic [1:0] PRL_SPD_100M = 2'h1;

	// Code bands of the rate table
	localparam logic [6:0] PRL_CODE_COARSE_MAX = 7'h0a;
	localparam logic [6:0] PRL_CODE_MID_MAX    = 7'h64;
	localparam logic [6:0] PRL_CODE_FINE_MAX   = 7'h73;
	localparam logic [6:0] PRL_CODE_F100_MAX   = 7'h67;

	// Bit rates in kbit/s
	localparam logic [31:0] PRL_BPS_LINE_10M  = 32'h0000_2710;
	localparam logic [31:0] PRL_BPS_LINE_100M = 32'h0001_86a0;
	localparam logic [31:0] PRL_BPS_LINE_1G   = 32'h000f_4240;
	localparam logic [31:0] PRL_BPS_STEP      = 32'h0000_03e8;
	localparam logic [31:0] PRL_BPS_STEP_1G   = 32'h0000_2710;
	localparam logic [31:0] PRL_BPS_FINE      = 32'h0000_0040;
	localparam logic [31:0] PRL_BPS_FINE_HI   = 32'h0000_0280;

	// Packet rates in packets per second
	localparam logic [31:0] PRL_PPS_LINE_10M  = 32'h0000_4b00;
	localparam logic [31:0] PRL_PPS_LINE_100M = 32'h0002_ee00;
	localparam logic [31:0] PRL_PPS_LINE_1G   = 32'h001d_4c00;
	localparam logic [31:0] PRL_PPS_STEP      = 32'h0000_0780;
	localparam logic [31:0] PRL_PPS_STEP_1G   = 32'h0000_4b00;
	localparam logic [31:0] PRL_PPS_FINE_1ST  = 32'h0000_0040;
	localparam logic [31:0] PRL_PPS_FINE_STEP = 32'h0000_0080;
	localparam logic [31:0] PRL_FINE_SCALE_1G = 32'h0000_000a;

	typedef logic [PRL_CODE_W-1:0] prl_code_t;
	typedef logic [PRL_RATE_W-1:0] prl_rate_t;

	// State of one port's limiter bank
	typedef struct packed {
		prl_code_t [PRL_ING_CODES-1:0] ing_staged;
		prl_code_t [PRL_ING_CODES-1:0] ing_active;
		prl_code_t [PRL_EGR_CODES-1:0] egr_staged;
		prl_code_t [PRL_EGR_CODES-1:0] egr_active;
	} prl_bank_t;

	// Decoded limits handed to the shaper of one port
	typedef struct packed {
		prl_rate_t [PRL_ING_CODES-1:0] ing_rate;
		prl_rate_t [PRL_EGR_CODES-1:0] egr_rate;
		logic      [PRL_EGR_CODES-1:0] egr_en;
	} prl_port_rate_t;

	// Port setup given by the MAC side
	typedef struct packed {
		logic [1:0] speed;
		logic       packets_per_second;
	} prl_port_cfg_t;

	// State of the bus slave
	typedef struct packed {
		logic                             ack;
		logic [PRL_DATA_W-1:0]            rdata;
		logic                             port_based;
		prl_port_rate_t [PRL_PORTS-1:0]   rates;
	} prl_top_t;
endpackage
`default_nettype wire

// *** rtl/prl_port_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
module prl_port_bank (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  wr_ing,
	input  wire logic                  wr_egr,
	input  wire logic [2:0]            wr_sel,
	input  wire logic [6:0]            wr_code,
	output prl_pkg::prl_bank_t         bank
);
	prl_pkg::prl_bank_t s_q;
	prl_pkg::prl_bank_t s_d;

	// Staged copy takes every write; commit writes copy the whole group
	always_comb begin
		s_d = s_q;
		if (wr_ing) begin
			s_d.ing_staged[wr_sel] = wr_code; // RULE2
			if (wr_sel == prl_pkg::PRL_IDX_ING_COMMIT[2:0]) begin
				s_d.ing_active = s_d.ing_staged; // RULE3
			end
		end
		if (wr_egr) begin
			s_d.egr_staged[wr_sel[1:0]] = wr_code; // RULE4
			if (wr_sel[1:0] == prl_pkg::PRL_IDX_EGR_COMMIT[1:0]) begin
				s_d.egr_active = s_d.egr_staged; // RULE5
			end
		end
		if (rst) begin
			s_d = {($bits(prl_pkg::prl_bank_t) / prl_pkg::PRL_CODE_W)
				{prl_pkg::PRL_CODE_RST}}; // RULE2 RULE4
		end
	end

	always_ff @(posedge mclk) begin
		s_q <= s_d;
	end

	assign bank = s_q;
endmodule
`default_nettype wire

// *** rtl/prl_rate_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module prl_rate_decode (
	input  wire logic [6:0]            code,
	input  wire logic [1:0]            speed,
	input  wire logic                  packets_per_second,
	output logic [20:0]                rate
);
	logic [31:0] c;
	logic [31:0] n;
	logic [31:0] line;
	logic [31:0] base;
	logic [31:0] r;
	logic        is1g;

	// Table lookup; codes above the fine band are unused and give line rate
	always_comb begin
		c    = 32'(code);
		n    = c - 32'(prl_pkg::PRL_CODE_MID_MAX);
		is1g = speed[1];
		base = '0;
		if (packets_per_second) begin
			line = is1g ? prl_pkg::PRL_PPS_LINE_1G :
				(speed == prl_pkg::PRL_SPD_100M) ?
				prl_pkg::PRL_PPS_LINE_100M : prl_pkg::PRL_PPS_LINE_10M;
		end else begin
			line = is1g ? prl_pkg::PRL_BPS_LINE_1G :
				(speed == prl_pkg::PRL_SPD_100M) ?
				prl_pkg::PRL_BPS_LINE_100M : prl_pkg::PRL_BPS_LINE_10M;
		end
		if (code == '0 || code > prl_pkg::PRL_CODE_FINE_MAX) begin
			r = line; // RULE8
		end else if (code <= prl_pkg::PRL_CODE_COARSE_MAX) begin
			r = packets_per_second ? (is1g ? prl_pkg::PRL_PPS_STEP_1G * c :
				prl_pkg::PRL_PPS_STEP * c) : prl_pkg::PRL_BPS_STEP * c;
		end else if (code <= prl_pkg::PRL_CODE_MID_MAX) begin
			// 10M cannot go finer than its line rate in this band
			if (speed == prl_pkg::PRL_SPD_10M) begin
				r = line;
			end else if (packets_per_second) begin
				r = is1g ? prl_pkg::PRL_PPS_STEP_1G * c :
					prl_pkg::PRL_PPS_STEP * c;
			end else begin
				r = is1g ? prl_pkg::PRL_BPS_STEP_1G * c :
					prl_pkg::PRL_BPS_STEP * c;
			end
		end else if (packets_per_second) begin
			base = (n == 32'h0000_0001) ? prl_pkg::PRL_PPS_FINE_1ST :
				prl_pkg::PRL_PPS_FINE_STEP * (n - 32'h0000_0001);
			r = is1g ? base * prl_pkg::PRL_FINE_SCALE_1G : base;
		end else if (is1g || (speed == prl_pkg::PRL_SPD_100M &&
				code <= prl_pkg::PRL_CODE_F100_MAX)) begin
			r = prl_pkg::PRL_BPS_FINE_HI * n;
		end else begin
			r = prl_pkg::PRL_BPS_FINE * n;
		end
		rate = r[20:0];
	end
endmodule
`default_nettype wire

// *** rtl/prl_rate_limit_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module prl_rate_limit_regs (
	input  wire logic                                mclk,
	input  wire logic                                rst,
	input  wire logic [17:0]                         avs_address,
	input  wire logic                                avs_read,
	input  wire logic                                avs_write,
	input  wire logic [31:0]                         avs_writedata,
	input  wire logic [3:0]                          avs_byteenable,
	output logic [31:0]                              avs_readdata,
	output logic                                     avs_waitrequest,
	input  wire prl_pkg::prl_port_cfg_t [5:0]        port_cfg,
	output prl_pkg::prl_port_rate_t [5:0]            port_rates
);
	localparam int NP = prl_pkg::PRL_PORTS;
	localparam int NI = prl_pkg::PRL_ING_CODES;
	localparam int NE = prl_pkg::PRL_EGR_CODES;

	// The slot table must match the port vector widths
	if ($size(prl_pkg::PRL_PORT_NUM) != 6 || NP != 6) begin : g_chk
		$error("prl_rate_limit_regs: port slot count must be six");
	end

	prl_pkg::prl_top_t                 s_q;
	prl_pkg::prl_top_t                 s_d;
	prl_pkg::prl_bank_t [NP-1:0]       bank;
	prl_pkg::prl_port_rate_t [NP-1:0]  rate_c;
	logic [15:0]                       idx;
	logic                              req;
	logic                              fire;
	logic                              ing_hit;
	logic                              egr_hit;
	logic [NP-1:0]                     port_hit;
	logic [NP-1:0]                     ing_pend;
	logic [NP-1:0]                     egr_pend;
	logic [NP-1:0]                     wr_ing;
	logic [NP-1:0]                     wr_egr;

	// Address split: high nibble picks the port, low bits the register
	assign idx     = avs_address[17:2];
	assign req     = avs_read | avs_write;
	assign fire    = avs_write & s_q.ack;
	assign ing_hit = idx[11:3] == prl_pkg::PRL_IDX_ING_BASE[11:3]; // RULE1
	assign egr_hit = idx[11:2] == prl_pkg::PRL_IDX_EGR_BASE[11:2];

	// One wait cycle per access keeps read data registered
	assign avs_waitrequest = req & ~s_q.ack;
	assign avs_readdata    = s_q.rdata;
	assign port_rates      = s_q.rates;

	for (genvar i = 0; i < NP; i++) begin : g_port
		assign port_hit[i] =
			idx[15:12] == prl_pkg::PRL_PORT_NUM[i]; // RULE1
		// Writes land at the edge where waitrequest is low
		assign wr_ing[i] = fire & avs_byteenable[0] & port_hit[i] &
			ing_hit;
		assign wr_egr[i] = fire & avs_byteenable[0] & port_hit[i] &
			egr_hit;
		assign ing_pend[i] = bank[i].ing_staged != bank[i].ing_active;
		assign egr_pend[i] = bank[i].egr_staged != bank[i].egr_active;

		prl_port_bank u_bank (
			.mclk    (mclk),
			.rst     (rst),
			.wr_ing  (wr_ing[i]),
			.wr_egr  (wr_egr[i]),
			.wr_sel  (idx[2:0]),
			.wr_code (avs_writedata[6:0]), // RULE9
			.bank    (bank[i])
		);

		for (genvar j = 0; j < NI; j++) begin : g_ing
			prl_rate_decode u_dec (
				.code  (bank[i].ing_active[j]),
				.speed (port_cfg[i].speed),
				.packets_per_second   (port_cfg[i].packets_per_second),
				.rate  (rate_c[i].ing_rate[j]) // RULE8
			);
		end

		for (genvar j = 0; j < NE; j++) begin : g_egr
			prl_rate_decode u_dec (
				.code  (bank[i].egr_active[j]),
				.speed (port_cfg[i].speed),
				.packets_per_second   (port_cfg[i].packets_per_second),
				.rate  (rate_c[i].egr_rate[j]) // RULE8
			);
		end

		// Port-based shaping keeps queue 0 only; others idle
		assign rate_c[i].egr_en = s_q.port_based ?
			{{(NE-1){1'b0}}, 1'b1} : {NE{1'b1}}; // RULE6 RULE7
	end

	// Bus slave, mode register and registered rate outputs
	always_comb begin
		s_d       = s_q;
		s_d.ack   = req & ~s_q.ack;
		s_d.rates = rate_c;
		for (int i = 0; i < NP; i++) begin
			for (int j = 1; j < NE; j++) begin
				if (s_q.port_based) begin
					s_d.rates[i].egr_rate[j] = '0; // RULE6 RULE7
				end
			end
		end
		if (req & ~s_q.ack) begin
			s_d.rdata = '0; // RULE9
			if (idx == prl_pkg::PRL_IDX_MODE) begin
				s_d.rdata[prl_pkg::PRL_MODE_PORT_BIT] = s_q.port_based;
			end else if (idx == prl_pkg::PRL_IDX_STATUS) begin
				s_d.rdata[NP-1:0] = ing_pend;
				s_d.rdata[prl_pkg::PRL_STAT_EGR_LSB +: NP] = egr_pend;
			end else begin
				for (int i = 0; i < NP; i++) begin
					if (port_hit[i] && ing_hit) begin
						s_d.rdata[6:0] = bank[i].ing_staged[idx[2:0]];
					end else if (port_hit[i] && egr_hit) begin
						s_d.rdata[6:0] = bank[i].egr_staged[idx[1:0]];
					end
				end
			end
		end
		if (fire && avs_byteenable[0] && idx == prl_pkg::PRL_IDX_MODE) begin
			s_d.port_based =
				avs_writedata[prl_pkg::PRL_MODE_PORT_BIT]; // RULE6
		end
		if (rst) begin
			s_d = '0;
		end
	end

	always_ff @(posedge mclk) begin
		s_q <= s_d;
	end
endmodule
`default_nettype wire

// *** verification/prl_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module prl_properties (
	input wire logic                          mclk,
	input wire logic                          rst,
	input wire logic [17:0]                   avs_address,
	input wire logic                          avs_read,
	input wire logic                          avs_write,
	input wire logic [31:0]                   avs_writedata,
	input wire logic [3:0]                    avs_byteenable,
	input wire logic [31:0]                   avs_readdata,
	input wire logic                          avs_waitrequest,
	input wire prl_pkg::prl_port_cfg_t [5:0]  port_cfg,
	input wire prl_pkg::prl_port_rate_t [5:0] port_rates
);
	logic        req, done, mode_q, mode_d;
	logic [11:0] idx;
	// Handshake and per-port index decode
	assign req  = avs_read | avs_write;
	assign done = req & ~avs_waitrequest;
	assign idx  = avs_address[13:2];
	// Shadow of the mode bit; the port side lags it by one edge
	always_comb begin
		mode_d = mode_q;
		if (done && avs_write && avs_byteenable[0] &&
			avs_address[17:2] == prl_pkg::PRL_IDX_MODE) begin
			mode_d = avs_writedata[prl_pkg::PRL_MODE_PORT_BIT];
		end
	end
	always_ff @(posedge mclk) begin
		mode_q <= rst ? 1'b0 : mode_d;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	AST_ONE_WAIT: assert property (
		req && avs_waitrequest |=> !avs_waitrequest)
		else $error("access waited more than one cycle");
	AST_IDLE_NO_WAIT: assert property (
		!req |-> !avs_waitrequest)
		else $error("waitrequest high with no access");
	// Status reads carry egress pending flags above bit 7
	AST_RSV_ZERO: assert property (
		done && avs_read && avs_address[17:2] != prl_pkg::PRL_IDX_STATUS
		|-> avs_readdata[31:7] == '0)
		else $error("reserved read data bits not zero");
	AST_RST_RDATA: assert property (
		disable iff (1'b0) rst |=> avs_readdata == '0)
		else $error("read data not cleared by reset");
	AST_ING_PEND: assert property (done && avs_write && idx >= 12'h410 &&
		idx < 12'h417 && $stable(port_cfg) |=> $stable(port_rates))
		else $error("staged ingress write changed the rates");
	AST_EGR_PEND: assert property (done && avs_write && idx >= 12'h420 &&
		idx < 12'h423 && $stable(port_cfg) |=> $stable(port_rates))
		else $error("staged egress write changed the rates");
	for (genvar i = 0; i < 6; i++) begin : g_slot
		AST_PORT_MODE: assert property (mode_q && $past(mode_q) |->
			port_rates[i].egr_en == 4'h1 && port_rates[i].egr_rate[3:1] == '0)
			else $error("port mode left queues 1 to 3 active");
		// Rates still hold their cleared value one edge after reset
		AST_QUEUE_MODE: assert property (!mode_q && !$past(mode_q) &&
			!$past(rst) |-> port_rates[i].egr_en == 4'hf)
			else $error("queue mode did not enable every queue");
	end
	// Main traffic: ingress commit, egress commit, port-based mode held two cycles
	COV_ING: cover property (done && avs_write && idx == 12'h417);
	COV_EGR: cover property (done && avs_write && idx == 12'h423);
	COV_MODE: cover property (mode_q && $past(mode_q));
endmodule
bind prl_rate_limit_regs prl_properties i_props (.mclk(mclk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.port_cfg(port_cfg), .port_rates(port_rates));
`default_nettype wire

// *** verification/test_port_rate_limit_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_port_rate_limit_regs;
	logic                         mclk, rst, rd, wr, wq;
	logic [17:0]                  adr;
	logic [31:0]                  wd, rdat, q;
	logic [3:0]                   be;
	prl_pkg::prl_port_cfg_t [5:0] cfg;
	prl_pkg::prl_port_rate_t [5:0] rt;
	int                           n_mismatch = 0, checked = 0, cyc = 0;
	prl_rate_limit_regs i_dut (.mclk(mclk), .rst(rst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
		.port_cfg(cfg), .port_rates(rt));
	// 100 ns clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Watchdog, so a stuck handshake still reaches the verdict
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [17:0] ra(input logic [3:0] p, input int i);
		return {p, 12'(i), 2'h0};
	endfunction
	// Expected kbit/s at 100M for codes 0 to 10
	function automatic logic [31:0] r100(input int c);
		return (c == 0) ? prl_pkg::PRL_BPS_LINE_100M : prl_pkg::PRL_BPS_STEP * c;
	endfunction
	// One access: raised just after an edge, held until waitrequest is
	// sampled low at a rising edge; read data is taken at that same edge.
	// The leading edge keeps a release and the next raise apart.
	task automatic bus(input logic w, input logic [17:0] a,
		input logic [31:0] d, input logic [3:0] e);
		@(posedge mclk);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wd <= d;
		be <= e;
		do begin
			@(posedge mclk);
		end while (wq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic settle();
		repeat (2) @(negedge mclk);
	endtask
	task automatic t_reset();
		for (int j = 0; j < 9; j++) begin
			bus(1'b0, ra(4'h1, (j < 7) ? 'h411 + j : 'h419 + j), 0, 4'hf);
			chk("reset code", q, 32'h0000_0000);
		end
		chk("line rate", 32'(rt[0].ing_rate[1]), r100(0));
		chk("queue enables", 32'(rt[0].egr_en), 32'h0000_000f);
		$display("reset test done");
	endtask
	// Every port: staged codes stay idle until priority 7 is written
	task automatic t_ingress();
		logic [3:0] p;
		for (int s = 0; s < 6; s++) begin
			p = prl_pkg::PRL_PORT_NUM[s];
			for (int i = 1; i < 7; i++) bus(1'b1, ra(p, 'h410 + i), 'h80 + i, 4'hf);
			bus(1'b0, ra(p, 'h413), 0, 4'hf);
			chk("code read back", q, 32'h0000_0003);
			bus(1'b0, 18'h0_00c4, 0, 4'hf);
			chk("ingress pending", q, 32'h0000_0001 << s);
			settle();
			chk("pending rate", 32'(rt[s].ing_rate[3]), r100(0));
			bus(1'b1, ra(p, 'h417), 7, 4'hf);
			settle();
			for (int i = 0; i < 8; i++) begin
				chk("ingress rate", 32'(rt[s].ing_rate[i]), r100(i));
			end
			if (s < 5) chk("other port", 32'(rt[s + 1].ing_rate[7]), r100(0));
		end
		$display("ingress test done");
	endtask
	task automatic t_egress();
		for (int i = 0; i < 3; i++) bus(1'b1, ra(4'h7, 'h420 + i), i + 3, 4'hf);
		bus(1'b0, 18'h0_00c4, 0, 4'hf);
		chk("egress pending", q, 32'h0000_2000);
		settle();
		chk("pending egress", 32'(rt[5].egr_rate[0]), r100(0));
		bus(1'b1, ra(4'h7, 'h423), 6, 4'hf);
		settle();
		for (int i = 0; i < 4; i++) begin
			chk("egress rate", 32'(rt[5].egr_rate[i]), r100(i + 3));
		end
		bus(1'b1, 18'h0_00c0, 8, 4'hf);
		settle();
		chk("port enables", 32'(rt[5].egr_en), 32'h0000_0001);
		chk("port rate", 32'(rt[5].egr_rate[0]), r100(3));
		chk("queue 1 off", 32'(rt[5].egr_rate[1]), 32'h0000_0000);
		bus(1'b0, 18'h0_00c0, 0, 4'hf);
		chk("mode read", q, 32'h0000_0008);
		bus(1'b1, 18'h0_00c0, 0, 4'hf);
		settle();
		chk("queue 1 back", 32'(rt[5].egr_rate[1]), r100(4));
		$display("egress test done");
	endtask
	task automatic t_refuse();
		bus(1'b1, ra(4'h1, 'h411), 9, 4'h0);
		bus(1'b0, ra(4'h1, 'h411), 0, 4'hf);
		chk("masked write", q, 32'h0000_0001);
		bus(1'b0, ra(4'h5, 'h417), 0, 4'hf);
		chk("absent port", q, 32'h0000_0000);
		$display("refusal test done");
	endtask
	// Gigabit packet mode on slot 0 decodes the same codes anew
	task automatic t_decode();
		@(posedge mclk);
		cfg[0] <= 3'h5;
		settle();
		chk("pps line", 32'(rt[0].ing_rate[0]), prl_pkg::PRL_PPS_LINE_1G);
		chk("pps step", 32'(rt[0].ing_rate[1]), prl_pkg::PRL_PPS_STEP_1G);
		$display("decode test done");
	endtask
	// Reset in mid-run must clear what the earlier tests left behind
	task automatic t_rerun();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		bus(1'b0, ra(4'h1, 'h411), 0, 4'hf);
		chk("code after reset", q, 32'h0000_0000);
		settle();
		chk("reset rate", 32'(rt[0].ing_rate[1]), prl_pkg::PRL_PPS_LINE_1G);
		chk("reset enables", 32'(rt[5].egr_en), 32'h0000_000f);
		$display("mid-run reset test done");
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		{rd, wr, adr, wd, be} = '0;
		cfg = {6{3'h2}};
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_ingress();
		t_egress();
		t_refuse();
		t_decode();
		t_rerun();
		summarize();
	end
endmodule
`default_nettype wire
